// File: logic/pcde_pkg.sv
// shared constants, register map and types for the port c/d/e block
// assumes one 20 MHz core clock and an 8-bit register port

package pcde_pkg;

  // --------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------
  localparam int unsigned PCDE_AW     = 8;
  localparam int unsigned PCDE_DW     = 8;
  localparam int unsigned PCDE_E_PINS = 3;

  // --------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------
  localparam logic [7:0] PCDE_ADDR_PORT_C_DATA  = 8'h07;
  localparam logic [7:0] PCDE_ADDR_PORT_D_DATA  = 8'h08;
  localparam logic [7:0] PCDE_ADDR_PORT_E_DATA  = 8'h09;
  localparam logic [7:0] PCDE_ADDR_PORT_C_DIR   = 8'h87;
  localparam logic [7:0] PCDE_ADDR_PORT_D_DIR   = 8'h88;
  localparam logic [7:0] PCDE_ADDR_PORT_E_CTRL  = 8'h89;
  localparam logic [7:0] PCDE_ADDR_ANALOG_CFG   = 8'h9f;

  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] PCDE_DIR_RESET         = 8'hff;
  localparam logic [2:0] PCDE_E_DIR_RESET       = 3'h7;
  localparam logic [2:0] PCDE_ANALOG_CFG_RESET  = 3'h0;
  localparam logic [7:0] PCDE_LATCH_RESET       = 8'h00;
  localparam logic [2:0] PCDE_ANALOG_ALL_DIGITAL = 3'h7;
  localparam logic [7:0] PCDE_ZERO              = 8'h00;

  // --------------------------------------------------------------------
  // port e control register fields
  // --------------------------------------------------------------------
  localparam int unsigned PCDE_IBF_BIT  = 7;
  localparam int unsigned PCDE_OBF_BIT  = 6;
  localparam int unsigned PCDE_INPUT_BUFFER_OVERFLOW_BIT = 5;
  localparam int unsigned PCDE_PSP_BIT  = 4;

  // port e pin roles in parallel mode
  localparam int unsigned PCDE_RD_PIN = 0;
  localparam int unsigned PCDE_WR_PIN = 1;
  localparam int unsigned PCDE_CS_PIN = 2;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PCDE_PSP_IDLE  = 2'b00,
    PCDE_PSP_WRITE = 2'b01,
    PCDE_PSP_READ  = 2'b10
  } pcde_psp_state_e;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pcde_bus_s;

  // port e pins that read as analog for a given pin configuration
  function automatic logic [2:0] pcde_e_analog(input logic [2:0] cfg);
    pcde_e_analog = (cfg == PCDE_ANALOG_ALL_DIGITAL) ? 3'h0 : 3'h7;
  endfunction : pcde_e_analog

endpackage : pcde_pkg

// File: logic/pcde_pin_drv.sv
// registered pin driver: output latch or alternate source per pin
// assumes direction bit 1 = input (released), 0 = drive from latch

`timescale 1ns/100ps

module pcde_pin_drv
  import pcde_pkg::*;
#(
  parameter int unsigned W = 8
)
(
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] latch_val,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] alt_sel,
  input  wire logic [W-1:0] alt_val,
  input  wire logic [W-1:0] alt_oe,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe
);

  logic [W-1:0] next_out;
  logic [W-1:0] next_oe;

  // ----------------------------------------------------------------------
  // per-pin source select
  // ----------------------------------------------------------------------
  // alt enable is masked by select, so a stray peripheral enable is inert
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (alt_sel[i])
      begin
        next_out[i] = alt_val[i];
        next_oe[i]  = alt_oe[i];
      end
      else
      begin
        next_out[i] = latch_val[i];
        next_oe[i]  = ~dir[i];
      end
    end
  end

  // registered so every pin output comes straight from a flop
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_out <= '0;
      pin_oe  <= '0;
    end
    else
    begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end

endmodule : pcde_pin_drv

// File: logic/pcde_ports.sv
// port c, d and e general i/o with parallel slave port select
// assumes pins synchronous to clk_sys, one-cycle register strobes,
// rst_b is power-on reset, warm_rst is a one-cycle other-reset pulse
//
// The plain strobed port was decided locally.

`timescale 1ns/100ps

module pcde_ports
  import pcde_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       warm_rst,
  input  wire pcde_bus_s  bus,
  output logic      [7:0] bus_rdata,
  input  wire logic [7:0] pc_in,
  output logic      [7:0] pc_out,
  output logic      [7:0] pc_oe,
  input  wire logic [7:0] periph_sel,
  input  wire logic [7:0] periph_out,
  input  wire logic [7:0] periph_oe,
  input  wire logic [7:0] pd_in,
  output logic      [7:0] pd_out,
  output logic      [7:0] pd_oe,
  input  wire logic [2:0] pe_in,
  output logic      [2:0] pe_out,
  output logic      [2:0] pe_oe
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0]      pc_latch;
  logic [7:0]      pd_latch;
  logic [2:0]      pe_latch;
  logic [7:0]      pc_dir;
  logic [7:0]      pd_dir;
  logic [2:0]      pe_dir;
  logic            psp_mode;
  logic            input_buffer_full;
  logic            output_buffer_full;
  logic            input_buffer_overflow;
  logic [2:0]      analog_cfg;
  logic [7:0]      psp_in_latch;
  pcde_psp_state_e state;
  pcde_psp_state_e next_state;
  logic [7:0]      next_rdata;

  logic            rd_n;
  logic            wr_n;
  logic            cs_n;
  logic            psp_sel;
  logic            write_done;
  logic            read_start;
  logic            pd_ext_drive;

  // ----------------------------------------------------------------------
  // register strobes
  // ----------------------------------------------------------------------
  function automatic logic wr_hit(input pcde_bus_s b, input logic [7:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction : wr_hit

  function automatic logic rd_hit(input pcde_bus_s b, input logic [7:0] a);
    rd_hit = b.rd && (b.addr == a);
  endfunction : rd_hit

  // ----------------------------------------------------------------------
  // parallel slave strobes
  // ----------------------------------------------------------------------
  // port e pins double as the external master's strobes
  assign rd_n    = pe_in[PCDE_RD_PIN];
  assign wr_n    = pe_in[PCDE_WR_PIN];
  assign cs_n    = pe_in[PCDE_CS_PIN];
  // unselected master: read and write strobes count for nothing
  assign psp_sel = psp_mode && !cs_n;

  assign write_done   = (state == PCDE_PSP_WRITE) && psp_mode
                        && (cs_n || wr_n);
  assign read_start   = (state == PCDE_PSP_IDLE) && psp_sel && !rd_n
                        && wr_n;
  assign pd_ext_drive = psp_sel && !rd_n;

  // strobe sequencer; write wins if both strobes fall together, except that pd_ext_drive still drives port d for the read
  always_comb
  begin
    next_state = state;
    case (state)
      PCDE_PSP_IDLE:
      begin
        if (psp_sel && !wr_n)
          next_state = PCDE_PSP_WRITE;
        else if (psp_sel && !rd_n)
          next_state = PCDE_PSP_READ;
      end
      PCDE_PSP_WRITE:
      begin
        if (!psp_mode || cs_n || wr_n)
          next_state = PCDE_PSP_IDLE;
      end
      PCDE_PSP_READ:
      begin
        if (!psp_mode || cs_n || rd_n)
          next_state = PCDE_PSP_IDLE;
      end
      default:
        next_state = PCDE_PSP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state <= PCDE_PSP_IDLE;
    else if (warm_rst)
      state <= PCDE_PSP_IDLE;
    else
      state <= next_state;
  end

  // input latch follows the bus while the master writes
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      psp_in_latch <= PCDE_LATCH_RESET;
    else if (psp_sel && !wr_n)
      psp_in_latch <= pd_in;
  end

  // ----------------------------------------------------------------------
  // output latches
  // ----------------------------------------------------------------------
  // latches survive warm reset; power-on value is don't-care
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_latch <= PCDE_LATCH_RESET;
      pd_latch <= PCDE_LATCH_RESET;
      pe_latch <= PCDE_LATCH_RESET[2:0];
    end
    else
    begin
      if (wr_hit(bus, PCDE_ADDR_PORT_C_DATA))
        pc_latch <= bus.wdata;
      if (wr_hit(bus, PCDE_ADDR_PORT_D_DATA))
        pd_latch <= bus.wdata;
      if (wr_hit(bus, PCDE_ADDR_PORT_E_DATA))
        pe_latch <= bus.wdata[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // direction and configuration registers
  // ----------------------------------------------------------------------
  // every reset kind releases all pins not under peripheral select and returns port e to analog
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_dir     <= PCDE_DIR_RESET;
      pd_dir     <= PCDE_DIR_RESET;
      pe_dir     <= PCDE_E_DIR_RESET;
      psp_mode   <= 1'b0;
      analog_cfg <= PCDE_ANALOG_CFG_RESET;
    end
    else if (warm_rst)
    begin
      pc_dir     <= PCDE_DIR_RESET;
      pd_dir     <= PCDE_DIR_RESET;
      pe_dir     <= PCDE_E_DIR_RESET;
      psp_mode   <= 1'b0;
      analog_cfg <= PCDE_ANALOG_CFG_RESET;
    end
    else
    begin
      if (wr_hit(bus, PCDE_ADDR_PORT_C_DIR))
        pc_dir <= bus.wdata;
      if (wr_hit(bus, PCDE_ADDR_PORT_D_DIR))
        pd_dir <= bus.wdata;
      if (wr_hit(bus, PCDE_ADDR_PORT_E_CTRL))
      begin
        pe_dir   <= bus.wdata[2:0];
        psp_mode <= bus.wdata[PCDE_PSP_BIT];
      end
      if (wr_hit(bus, PCDE_ADDR_ANALOG_CFG))
        analog_cfg <= bus.wdata[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // parallel port status flags
  // ----------------------------------------------------------------------
  // buffer flags are held clear outside parallel mode; set beats clear
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      input_buffer_full <= 1'b0;
      output_buffer_full <= 1'b0;
    end
    else if (warm_rst || !psp_mode)
    begin
      input_buffer_full <= 1'b0;
      output_buffer_full <= 1'b0;
    end
    else
    begin
      if (write_done)
        input_buffer_full <= 1'b1;
      else if (rd_hit(bus, PCDE_ADDR_PORT_D_DATA))
        input_buffer_full <= 1'b0;
      if (wr_hit(bus, PCDE_ADDR_PORT_D_DATA))
        output_buffer_full <= 1'b1;
      else if (read_start)
        output_buffer_full <= 1'b0;
    end
  end

  // overflow stays after leaving parallel mode; software clears it
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      input_buffer_overflow <= 1'b0;
    else if (warm_rst)
      input_buffer_overflow <= 1'b0;
    else if (write_done && input_buffer_full)
      input_buffer_overflow <= 1'b1;
    else if (wr_hit(bus, PCDE_ADDR_PORT_E_CTRL))
      input_buffer_overflow <= bus.wdata[PCDE_INPUT_BUFFER_OVERFLOW_BIT];
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // data reads show pins, not latches, except port d in parallel mode (psp_in_latch) and analog port e pins (zero); so a pin held by a load reads low
  always_comb
  begin
    next_rdata = PCDE_ZERO;
    if (bus.rd)
    begin
      case (bus.addr)
        PCDE_ADDR_PORT_C_DATA:
          next_rdata = pc_in;
        PCDE_ADDR_PORT_D_DATA:
          next_rdata = psp_mode ? psp_in_latch : pd_in;
        PCDE_ADDR_PORT_E_DATA:
          next_rdata = {5'h00, pe_in & ~pcde_e_analog(analog_cfg)};
        PCDE_ADDR_PORT_C_DIR:
          next_rdata = pc_dir;
        PCDE_ADDR_PORT_D_DIR:
          next_rdata = pd_dir;
        PCDE_ADDR_PORT_E_CTRL:
          next_rdata = {input_buffer_full, output_buffer_full, input_buffer_overflow, psp_mode, 1'b0, pe_dir};
        PCDE_ADDR_ANALOG_CFG:
          next_rdata = {5'h00, analog_cfg};
        default:
          next_rdata = PCDE_ZERO;
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      bus_rdata <= PCDE_ZERO;
    else
      bus_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  // peripheral wiring by bit: 0 timer1 osc out, 1 timer1 osc in or capture_compare_pwm_two,
  // 2 capture_compare_pwm_one, 3 sck/scl, 4 sdi/sda, 5 sdo, 6 uart tx/ck, 7 uart rx/dt
  pcde_pin_drv #(.W(8)) u_port_c
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .latch_val (pc_latch),
    .dir       (pc_dir),
    .alt_sel   (periph_sel),
    .alt_val   (periph_out),
    .alt_oe    (periph_oe),
    .pin_out   (pc_out),
    .pin_oe    (pc_oe)
  );

  // direction register is bypassed in parallel mode; master owns the bus
  pcde_pin_drv #(.W(8)) u_port_d
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .latch_val (pd_latch),
    .dir       (pd_dir),
    .alt_sel   ({8{psp_mode}}),
    .alt_val   (pd_latch),
    .alt_oe    ({8{pd_ext_drive}}),
    .pin_out   (pd_out),
    .pin_oe    (pd_oe)
  );

  // analog mode does not release the pin: software must keep it input
  pcde_pin_drv #(.W(3)) u_port_e
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .latch_val (pe_latch),
    .dir       (pe_dir),
    .alt_sel   (3'h0),
    .alt_val   (3'h0),
    .alt_oe    (3'h0),
    .pin_out   (pe_out),
    .pin_oe    (pe_oe)
  );

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  AST_PC_PERIPH_SEL: assert property (
    periph_sel[2] |=> pc_out[2] == $past(periph_out[2])
                      && pc_oe[2] == $past(periph_oe[2]))
    else $error("port c pin ignores peripheral select");

  AST_PC_PERIPH_OE_MASK: assert property (
    !periph_sel[1] && pc_dir[1] && periph_oe[1] |=> !pc_oe[1])
    else $error("peripheral enable drives unselected pin");

  AST_DIR_WARM_RESET: assert property (
    warm_rst |=> pc_dir == PCDE_DIR_RESET && pd_dir == PCDE_DIR_RESET
                 && pe_dir == PCDE_E_DIR_RESET && !psp_mode)
    else $error("direction registers not reset");

  AST_PD_GPIO_DIR: assert property (
    !psp_mode |=> pd_oe == ~$past(pd_dir) && pd_out == $past(pd_latch))
    else $error("port d general drive mismatch");

  AST_PSP_WRITE_DONE: assert property (
    psp_mode && state == PCDE_PSP_WRITE && (cs_n || wr_n) && !warm_rst
    |=> input_buffer_full)
    else $error("parallel write did not set buffer full");

  AST_PE_CTRL_READ: assert property (
    rd_hit(bus, PCDE_ADDR_PORT_E_CTRL)
    |=> bus_rdata[3] == 1'b0
        && bus_rdata[PCDE_PSP_BIT] == $past(psp_mode))
    else $error("port e control read wrong");

  AST_PE_ANALOG_ZERO: assert property (
    rd_hit(bus, PCDE_ADDR_PORT_E_DATA)
    && analog_cfg != PCDE_ANALOG_ALL_DIGITAL |=> bus_rdata == PCDE_ZERO)
    else $error("analog port e pin read nonzero");

  AST_PE_DIR_DRIVE: assert property (
    !pe_dir[1] |=> pe_oe[1])
    else $error("port e output not driven");

  AST_PSP_READ_DRIVE: assert property (
    psp_mode && !cs_n && !rd_n
    |=> pd_oe == 8'hff && pd_out == $past(pd_latch))
    else $error("parallel read did not drive latch");

  AST_PSP_UNSELECTED: assert property (
    psp_mode && cs_n && state == PCDE_PSP_IDLE
    |=> pd_oe == PCDE_ZERO && state == PCDE_PSP_IDLE)
    else $error("unselected strobes not ignored");

  AST_PC_READ_PINS: assert property (
    rd_hit(bus, PCDE_ADDR_PORT_C_DATA) |=> bus_rdata == $past(pc_in))
    else $error("port c read not pin level");

  AST_RDATA_IDLE: assert property (
    !bus.rd |=> bus_rdata == PCDE_ZERO)
    else $error("read data outside read cycle");

endmodule : pcde_ports

// File: tb/pcde_host_model.sv
// far side of the port block: external circuitry and a host processor
// assumes pin inputs of the block are fed only from this model

`timescale 1ns/100ps

module pcde_host_model
  import pcde_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] pc_out,
  input  wire logic [7:0] pc_oe,
  input  wire logic [7:0] pd_out,
  input  wire logic [7:0] pd_oe,
  input  wire logic [2:0] pe_out,
  input  wire logic [2:0] pe_oe,
  output logic      [7:0] pc_in,
  output logic      [7:0] pd_in,
  output logic      [2:0] pe_in
);
  // ------------------------------------------------------------------
  // pin resolution
  // ------------------------------------------------------------------
  logic [7:0] ext_c = 8'h00;
  logic [7:0] ext_d = 8'h00;
  logic [2:0] ext_e = 3'h7;  // strobes idle high

  // device driver wins on each enabled bit, ours elsewhere
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
  assign pd_in = (pd_oe & pd_out) | (~pd_oe & ext_d);
  assign pe_in = (pe_oe & pe_out) | (~pe_oe & ext_e);

  // ------------------------------------------------------------------
  // host cycles, all changes right after a rising edge
  // ------------------------------------------------------------------
  // plain levels on the port c and d pins
  task automatic set_ext(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_sys);
    ext_c <= c;
    ext_d <= d;
  endtask : set_ext

  // chip select and write low, data held until strobes back high
  task automatic psp_write(input logic [7:0] d);
    @(posedge clk_sys);
    ext_d <= d;
    ext_e <= 3'h1;
    repeat (2) @(posedge clk_sys);
    ext_e <= 3'h7;
    @(posedge clk_sys);
    ext_d <= ~d;  // released bus shows no stale value
    repeat (2) @(posedge clk_sys);
  endtask : psp_write

  // read strobe low; chip select low only when sel is set
  task automatic psp_read(input logic sel, output logic [7:0] q);
    @(posedge clk_sys);
    ext_e <= {~sel, 1'b1, 1'b0};
    ext_d <= ~ext_d;  // we stop driving; a lazy device reads wrong
    repeat (3) @(posedge clk_sys);
    #1 q = pd_in;
    @(posedge clk_sys);
    ext_e <= 3'h7;
    repeat (2) @(posedge clk_sys);
  endtask : psp_read
endmodule : pcde_host_model

// File: tb/pcde_ports_tb_top.sv
// self-checking bench for the port c/d/e block
// assumes the host model drives every pin input of the block

`timescale 1ns/100ps

module pcde_ports_tb_top
  import pcde_pkg::*;
;
  // ------------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } pcde_row_s;

  logic       clk_sys    = 1'b0;
  logic       rst_b      = 1'b0;
  logic       warm_rst   = 1'b0;
  pcde_bus_s  bus        = '0;
  logic [7:0] periph_sel = 8'h00;
  logic [7:0] periph_out = 8'h00;
  logic [7:0] periph_oe  = 8'h00;
  logic [7:0] bus_rdata, pc_in, pc_out, pc_oe, pd_in, pd_out, pd_oe;
  logic [2:0] pe_in, pe_out, pe_oe;
  logic [7:0] q, exp_o;
  int         err_total  = 0;
  int         checks     = 0;

  // writes, reads back, unmapped place, read-only bits
  pcde_row_s rows [6] = '{'{8'h87, 8'h5a, 8'h5a}, '{8'h88, 8'ha5, 8'ha5},
    '{8'h89, 8'h0a, 8'h02}, '{8'h9f, 8'hff, 8'h07},
    '{8'h55, 8'hff, 8'h00}, '{8'h89, 8'hc7, 8'h07}};

  always #25 clk_sys = ~clk_sys;

  pcde_ports i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .warm_rst(warm_rst),
    .bus(bus), .bus_rdata(bus_rdata), .pc_in(pc_in), .pc_out(pc_out),
    .pc_oe(pc_oe), .periph_sel(periph_sel), .periph_out(periph_out),
    .periph_oe(periph_oe), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
    .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe));

  pcde_host_model i_host (.clk_sys(clk_sys), .pc_out(pc_out),
    .pc_oe(pc_oe), .pd_out(pd_out), .pd_oe(pd_oe), .pe_out(pe_out),
    .pe_oe(pe_oe), .pc_in(pc_in), .pd_in(pd_in), .pe_in(pe_in));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("mismatches %0d of %0d checks", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // one-cycle strobes, one idle cycle between requests
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1 chk(bus_rdata, exp);
  endtask : rd

  // pins follow their cause one edge later; two give margin
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  // ------------------------------------------------------------------
  // hang guard
  // ------------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    $display("CHECK FAILED t=%0t run did not end", $time);
    results();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    settle();
    chk(pc_oe, 8'h00);
    rd(8'h87, 8'hff);
    rd(8'h88, 8'hff);
    rd(8'h89, 8'h07);
    rd(8'h09, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp);
    end
    // port c: bits 2,3 handed to peripheral, enables on bits 1,2, so only bit 2 is peripheral-driven
    wr(8'h87, 8'h0f);
    wr(8'h07, 8'ha5);
    @(posedge clk_sys);
    periph_sel <= 8'h0c;
    periph_out <= 8'hff;
    periph_oe  <= 8'h06;
    i_host.set_ext(8'h3c, 8'h3c);
    settle();
    chk(pc_oe, 8'hf4);
    exp_o = ((8'ha5 & ~8'h0c) | (8'hff & 8'h0c)) & 8'hf4;
    chk(pc_out & pc_oe, exp_o);
    rd(8'h07, exp_o | (8'h3c & ~8'hf4));
    // port d general i/o, low nibble driven
    wr(8'h88, 8'hf0);
    wr(8'h08, 8'h96);
    settle();
    chk(pd_oe, 8'h0f);
    rd(8'h08, (8'h96 & 8'h0f) | (8'h3c & 8'hf0));
    // port e outputs while analog: driven, yet read as zero
    wr(8'h9f, 8'h00);
    wr(8'h89, 8'h00);
    wr(8'h09, 8'h05);
    settle();
    chk({5'h00, pe_oe}, 8'h07);
    chk({5'h00, pe_out}, 8'h05);
    rd(8'h09, 8'h00);
    wr(8'h9f, 8'h07);
    rd(8'h09, 8'h05);
    wr(8'h89, 8'h07);
    // parallel mode ignores port d direction
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h17);
    settle();
    chk(pd_oe, 8'h00);
    wr(8'h08, 8'h3c);
    rd(8'h89, 8'h57);
    i_host.psp_read(1'b0, q);
    rd(8'h89, 8'h57);
    i_host.psp_read(1'b1, q);
    chk(q, 8'h3c);
    rd(8'h89, 8'h17);
    i_host.psp_write(8'h81);
    rd(8'h89, 8'h97);
    rd(8'h08, 8'h81);
    rd(8'h89, 8'h17);
    i_host.psp_write(8'h11);
    i_host.psp_write(8'h22);
    rd(8'h89, 8'hb7);
    wr(8'h89, 8'h17);
    rd(8'h89, 8'h97);
    // other reset: controls back to defaults, latches kept
    @(posedge clk_sys);
    periph_sel <= 8'h00;
    warm_rst   <= 1'b1;
    @(posedge clk_sys);
    warm_rst   <= 1'b0;
    rd(8'h89, 8'h07);
    rd(8'h87, 8'hff);
    rd(8'h88, 8'hff);
    rd(8'h09, 8'h00);
    wr(8'h87, 8'h00);
    settle();
    chk(pc_oe, 8'hff);
    chk(pc_out, 8'ha5);
    results();
  end
endmodule : pcde_ports_tb_top
